// ### rtl/ext_packet_mem.sv
// Nine-word store for the audio extension packet
`timescale 1ns/1ps
module ext_packet_mem import link_mirror_pkg::*; (
   input  wire logic        clock_i,
   input  wire logic        rst_n_i,
   input  wire logic        ce_i,
   input  wire logic        byte_we_i,
   input  wire logic [5:0]  byte_idx_i,
   input  wire logic [7:0]  byte_i,
   input  wire logic        rd_en_i,
   input  wire logic [3:0]  rd_idx_i,
   output logic      [31:0] rd_data_o
);
   typedef struct packed {
      logic [EXT_WORDS-1:0][31:0] mem;
      logic [31:0]                rd_data;
   } mem_s;
   mem_s st_ff;
   mem_s nxt_st;
   // =========================
   // Byte placement and read
   always_comb begin
      nxt_st = st_ff;
      if (byte_we_i && (byte_idx_i < EXT_BYTE_LIM)) begin // [R1] [R3] [R4]
         nxt_st.mem[byte_idx_i[5:2]][8*byte_idx_i[1:0] +: 8] = byte_i;
      end
      if (rd_en_i) begin
         nxt_st.rd_data = st_ff.mem[rd_idx_i];
      end
   end
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st_ff <= '0;
      end else if (ce_i) begin
         st_ff <= nxt_st;
      end
   end
   assign rd_data_o = st_ff.rd_data;
   // =========================
   // Checks
   property p_len_fixed;
      @(posedge clock_i) disable iff (!rst_n_i)
      (ce_i && byte_we_i && byte_idx_i >= EXT_BYTE_LIM) |=> $stable(st_ff.mem);
   endproperty
   a_len_fixed: assert property (p_len_fixed) // [R1]
      else $error("byte beyond packet was stored");
   property p_hdr_top;
      @(posedge clock_i) disable iff (!rst_n_i)
      (ce_i && byte_we_i && byte_idx_i == 6'h03)
      |=> st_ff.mem[0][31:24] == $past(byte_i);
   endproperty
   a_hdr_top: assert property (p_hdr_top) // [R3]
      else $error("header byte three misplaced");
   property p_last_byte;
      @(posedge clock_i) disable iff (!rst_n_i)
      (ce_i && byte_we_i && byte_idx_i == 6'h23)
      |=> st_ff.mem[8][31:24] == $past(byte_i);
   endproperty
   a_last_byte: assert property (p_last_byte) // [R4]
      else $error("payload byte 31 misplaced");
endmodule : ext_packet_mem

// ### rtl/link_config_store.sv
// Mirror of the link configuration set by the remote source
`timescale 1ns/1ps
module link_config_store import link_mirror_pkg::*; (
   input  wire logic       clock_i,
   input  wire logic       rst_n_i,
   input  wire logic       ce_i,
   input  wire logic       cfg_we_i,
   input  wire logic [2:0] cfg_sel_i,
   input  wire logic [7:0] cfg_data_i,
   output logic      [7:0] bw_o,
   output logic      [4:0] lanes_o,
   output logic            enh_o,
   output logic      [1:0] tp_o,
   output logic      [1:0] lqp_o,
   output logic            rclk_en_o,
   output logic            scr_off_o,
   output logic      [1:0] err_sel_o
);
   typedef struct packed {
      logic [7:0] bw;
      logic [4:0] lanes;
      logic       enh;
      logic [1:0] tp;
      logic [1:0] lqp;
      logic       rclk_en;
      logic       scr_off;
      logic [1:0] err_sel;
   } cfg_s;
   cfg_s st_ff;
   cfg_s nxt_st;
   // =========================
   // Field capture
   always_comb begin
      nxt_st = st_ff;
      if (cfg_we_i) begin // [R14]
         case (cfg_sel_i)
            SEL_BW:     nxt_st.bw      = cfg_data_i;
            SEL_LANES:  nxt_st.lanes   = cfg_data_i[4:0];
            SEL_ENH:    nxt_st.enh     = cfg_data_i[0];
            SEL_TP:     nxt_st.tp      = cfg_data_i[1:0];
            SEL_LQP:    nxt_st.lqp     = cfg_data_i[1:0];
            SEL_RCLK:   nxt_st.rclk_en = cfg_data_i[0];
            SEL_SCR:    nxt_st.scr_off = cfg_data_i[0];
            default:    nxt_st.err_sel = cfg_data_i[1:0];
         endcase
      end
   end
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st_ff <= '0;
      end else if (ce_i) begin
         st_ff <= nxt_st;
      end
   end
   assign bw_o      = st_ff.bw;
   assign lanes_o   = st_ff.lanes;
   assign enh_o     = st_ff.enh;
   assign tp_o      = st_ff.tp;
   assign lqp_o     = st_ff.lqp;
   assign rclk_en_o = st_ff.rclk_en;
   assign scr_off_o = st_ff.scr_off;
   assign err_sel_o = st_ff.err_sel;
   // =========================
   // Checks
   property p_only_link;
      @(posedge clock_i) disable iff (!rst_n_i)
      !cfg_we_i |=> $stable(st_ff);
   endproperty
   a_only_link: assert property (p_only_link) // [R14]
      else $error("mirror changed without a link write");
endmodule : link_config_store

// ### rtl/link_mirror_pkg.sv
// Shared constants and types for the link configuration mirror
package link_mirror_pkg;
   // =========================
   // Register offsets
   localparam logic [11:0] OFS_EXT_FIRST = 12'h330;
   localparam logic [11:0] OFS_EXT_LAST  = 12'h350;
   localparam logic [11:0] OFS_BW        = 12'h400;
   localparam logic [11:0] OFS_LANES     = 12'h404;
   localparam logic [11:0] OFS_ENH       = 12'h408;
   localparam logic [11:0] OFS_TP        = 12'h40C;
   localparam logic [11:0] OFS_LQP       = 12'h410;
   localparam logic [11:0] OFS_RCLK      = 12'h414;
   localparam logic [11:0] OFS_SCR       = 12'h418;
   localparam logic [11:0] OFS_ERRSEL    = 12'h41C;
   // =========================
   // Extension packet geometry
   localparam int          EXT_WORDS     = 9;
   localparam logic [3:0]  EXT_LAST_IDX  = 4'h8;
   localparam logic [3:0]  EXT_FIRST_IDX = 4'h0;
   localparam logic [5:0]  EXT_BYTE_LIM  = 6'h24;
   // =========================
   // Link-side field selects
   localparam logic [2:0]  SEL_BW        = 3'h0;
   localparam logic [2:0]  SEL_LANES     = 3'h1;
   localparam logic [2:0]  SEL_ENH       = 3'h2;
   localparam logic [2:0]  SEL_TP        = 3'h3;
   localparam logic [2:0]  SEL_LQP       = 3'h4;
   localparam logic [2:0]  SEL_RCLK      = 3'h5;
   localparam logic [2:0]  SEL_SCR       = 3'h6;
   localparam logic [2:0]  SEL_ERRSEL    = 3'h7;
   // =========================
   // Bandwidth codes
   localparam logic [7:0]  BW_1G62       = 8'h06;
   localparam logic [7:0]  BW_2G7        = 8'h0A;
   localparam logic [7:0]  BW_5G4        = 8'h14;
   // =========================
   // Bus responses and reset values
   localparam logic [1:0]  RESP_OKAY     = 2'h0;
   localparam logic [1:0]  RESP_SLVERR   = 2'h2;
   localparam logic [1:0]  RESP_DECERR   = 2'h3;
   localparam logic [1:0]  RST_SYNC      = 2'h0;
   localparam logic [31:0] RST_WORD      = 32'h0000_0000;
   // =========================
   // Read channel states
   typedef enum logic [2:0] {
      RD_IDLE = 3'h1,
      RD_WAIT = 3'h2,
      RD_RESP = 3'h4
   } rd_state_e;
endpackage : link_mirror_pkg

// ### rtl/sink_link_config_mirror.sv
// AXI4-Lite read-only register group: packet keyhole and config mirror
`timescale 1ns/1ps
// Functional notes
// R1: Extension packet is always 32 data bytes
// R2: Nine keyhole reads return successive words
// R3: First word holds header bytes, byte0 lowest
// R4: Words two to nine hold payload, ascending
// R5: Source must send 32-byte extension packets
// R6: Bandwidth code reported in bits 7:0
// R7: Lane count reported in bits 4:0
// R8: Bit 0 shows enhanced framing enabled
// R9: Two-bit training pattern code reported
// R10: Two-bit link quality pattern code reported
// R11: Flag drives recovered clock to test port
// R12: Bit 0 shows scrambling disabled
// R13: Two-bit symbol error count select reported
// R14: Mirror is read-only, reflects source values
// R15: Pointer wraps to first word after ninth
module sink_link_config_mirror import link_mirror_pkg::*; (
   input  wire logic        clock_i,
   input  wire logic        arst_n_i,
   input  wire logic        ce_i,
   input  wire logic [11:0] s_axi_awaddr_i,
   input  wire logic        s_axi_awvalid_i,
   output logic             s_axi_awready_o,
   input  wire logic [31:0] s_axi_wdata_i,
   input  wire logic [3:0]  s_axi_wstrb_i,
   input  wire logic        s_axi_wvalid_i,
   output logic             s_axi_wready_o,
   output logic      [1:0]  s_axi_bresp_o,
   output logic             s_axi_bvalid_o,
   input  wire logic        s_axi_bready_i,
   input  wire logic [11:0] s_axi_araddr_i,
   input  wire logic        s_axi_arvalid_i,
   output logic             s_axi_arready_o,
   output logic      [31:0] s_axi_rdata_o,
   output logic      [1:0]  s_axi_rresp_o,
   output logic             s_axi_rvalid_o,
   input  wire logic        s_axi_rready_i,
   input  wire logic        cfg_we_i,
   input  wire logic [2:0]  cfg_sel_i,
   input  wire logic [7:0]  cfg_data_i,
   input  wire logic        ext_byte_we_i,
   input  wire logic [5:0]  ext_byte_idx_i,
   input  wire logic [7:0]  ext_byte_i,
   input  wire logic        rec_clk_i,
   output logic             test_clk_o
);
   // =========================
   // State
   typedef struct packed {
      rd_state_e   rd_state;
      logic [11:0] addr;
      logic [31:0] rdata;
      logic [1:0]  rresp;
      logic        rvalid;
      logic        arready;
      logic        aw_got;
      logic        w_got;
      logic [11:0] awaddr;
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic [3:0]  ptr;
      logic        test_clk;
   } top_s;

   top_s        st_ff;
   top_s        nxt_st;
   logic [1:0]  rst_sync_ff;
   logic        rst_n;
   logic        mem_rd_en;
   logic [31:0] mem_rd_data;
   logic [7:0]  bw;
   logic [4:0]  lanes;
   logic        enh;
   logic [1:0]  tp;
   logic [1:0]  lqp;
   logic        rclk_en;
   logic        scr_off;
   logic [1:0]  err_sel;
   logic        ar_take;
   logic        kh_take;
   logic        aw_take;
   logic        w_take;

   // =========================
   // Address decode
   function automatic logic is_keyhole(input logic [11:0] a);
      is_keyhole = (a >= OFS_EXT_FIRST) && (a <= OFS_EXT_LAST) && (a[1:0] == 2'h0);
   endfunction : is_keyhole

   function automatic logic is_mapped(input logic [11:0] a);
      logic cfg_hit;
      cfg_hit = (a == OFS_BW) || (a == OFS_LANES) || (a == OFS_ENH) ||
                (a == OFS_TP) || (a == OFS_LQP) || (a == OFS_RCLK) ||
                (a == OFS_SCR) || (a == OFS_ERRSEL);
      is_mapped = cfg_hit || is_keyhole(a);
   endfunction : is_mapped

   // =========================
   // Reset release
   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rst_sync_ff <= RST_SYNC;
      end else if (ce_i) begin
         rst_sync_ff <= {rst_sync_ff[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_ff[1];

   // =========================
   // Submodules
   ext_packet_mem u_mem (
      .clock_i    (clock_i),
      .rst_n_i    (rst_n),
      .ce_i       (ce_i),
      .byte_we_i  (ext_byte_we_i),
      .byte_idx_i (ext_byte_idx_i),
      .byte_i     (ext_byte_i),
      .rd_en_i    (mem_rd_en),
      .rd_idx_i   (st_ff.ptr),
      .rd_data_o  (mem_rd_data)
   );

   link_config_store u_cfg (
      .clock_i    (clock_i),
      .rst_n_i    (rst_n),
      .ce_i       (ce_i),
      .cfg_we_i   (cfg_we_i),
      .cfg_sel_i  (cfg_sel_i),
      .cfg_data_i (cfg_data_i),
      .bw_o       (bw),
      .lanes_o    (lanes),
      .enh_o      (enh),
      .tp_o       (tp),
      .lqp_o      (lqp),
      .rclk_en_o  (rclk_en),
      .scr_off_o  (scr_off),
      .err_sel_o  (err_sel)
   );

   // =========================
   // Handshakes
   assign ar_take = st_ff.arready && s_axi_arvalid_i;
   assign kh_take = ar_take && is_keyhole(s_axi_araddr_i);
   assign aw_take = st_ff.awready && s_axi_awvalid_i;
   assign w_take  = st_ff.wready && s_axi_wvalid_i;

   // =========================
   // Next state
   always_comb begin
      nxt_st    = st_ff;
      mem_rd_en = 1'b0;
      nxt_st.test_clk = rclk_en && rec_clk_i; // [R11]
      case (st_ff.rd_state)
         RD_IDLE: begin
            nxt_st.arready = 1'b1;
            if (ar_take) begin
               nxt_st.addr     = s_axi_araddr_i;
               nxt_st.arready  = 1'b0;
               nxt_st.rd_state = RD_WAIT;
               if (kh_take) begin
                  mem_rd_en = 1'b1; // [R2]
                  if (st_ff.ptr == EXT_LAST_IDX) begin
                     nxt_st.ptr = EXT_FIRST_IDX; // [R15]
                  end else begin
                     nxt_st.ptr = st_ff.ptr + 4'h1; // [R2]
                  end
               end
            end
         end
         RD_WAIT: begin
            nxt_st.rvalid   = 1'b1;
            nxt_st.rresp    = RESP_OKAY;
            nxt_st.rd_state = RD_RESP;
            if (is_keyhole(st_ff.addr)) begin
               nxt_st.rdata = mem_rd_data; // [R3] [R4]
            end else begin
               case (st_ff.addr)
                  OFS_BW:     nxt_st.rdata = {24'h000000, bw}; // [R6]
                  OFS_LANES:  nxt_st.rdata = {27'h0000000, lanes}; // [R7]
                  OFS_ENH:    nxt_st.rdata = {31'h00000000, enh}; // [R8]
                  OFS_TP:     nxt_st.rdata = {30'h00000000, tp}; // [R9]
                  OFS_LQP:    nxt_st.rdata = {30'h00000000, lqp}; // [R10]
                  OFS_RCLK:   nxt_st.rdata = {31'h00000000, rclk_en}; // [R11]
                  OFS_SCR:    nxt_st.rdata = {31'h00000000, scr_off}; // [R12]
                  OFS_ERRSEL: nxt_st.rdata = {30'h00000000, err_sel}; // [R13]
                  default: begin
                     nxt_st.rdata = RST_WORD;
                     nxt_st.rresp = RESP_DECERR;
                  end
               endcase
            end
         end
         RD_RESP: begin
            if (s_axi_rready_i) begin
               nxt_st.rvalid   = 1'b0;
               nxt_st.arready  = 1'b1;
               nxt_st.rd_state = RD_IDLE;
            end
         end
         default: begin
            nxt_st.rvalid   = 1'b0;
            nxt_st.arready  = 1'b0;
            nxt_st.rd_state = RD_IDLE;
         end
      endcase
      // Write side: every write is refused, nothing is stored
      if (st_ff.bvalid && s_axi_bready_i) begin
         nxt_st.bvalid = 1'b0;
      end
      if (aw_take) begin
         nxt_st.aw_got = 1'b1;
         nxt_st.awaddr = s_axi_awaddr_i;
      end
      if (w_take) begin
         nxt_st.w_got = 1'b1;
      end
      if (nxt_st.aw_got && nxt_st.w_got && !st_ff.bvalid) begin
         nxt_st.bvalid = 1'b1;
         nxt_st.aw_got = 1'b0;
         nxt_st.w_got  = 1'b0;
         if (is_mapped(nxt_st.awaddr)) begin
            nxt_st.bresp = RESP_SLVERR; // [R14]
         end else begin
            nxt_st.bresp = RESP_DECERR;
         end
      end
      nxt_st.awready = !nxt_st.aw_got && !nxt_st.bvalid;
      nxt_st.wready  = !nxt_st.w_got && !nxt_st.bvalid;
   end

   always_ff @(posedge clock_i or negedge rst_n) begin
      if (!rst_n) begin
         st_ff          <= '0;
         st_ff.rd_state <= RD_IDLE;
      end else if (ce_i) begin
         st_ff <= nxt_st;
      end
   end

   // =========================
   // Outputs
   assign s_axi_awready_o = st_ff.awready;
   assign s_axi_wready_o  = st_ff.wready;
   assign s_axi_bresp_o   = st_ff.bresp;
   assign s_axi_bvalid_o  = st_ff.bvalid;
   assign s_axi_arready_o = st_ff.arready;
   assign s_axi_rdata_o   = st_ff.rdata;
   assign s_axi_rresp_o   = st_ff.rresp;
   assign s_axi_rvalid_o  = st_ff.rvalid;
   assign test_clk_o      = st_ff.test_clk;

   // =========================
   // Checks
   sequence s_read_of(logic [11:0] a);
      ar_take && s_axi_araddr_i == a && ce_i ##1 ce_i;
   endsequence

   property p_kh_step;
      @(posedge clock_i) disable iff (!rst_n)
      (ce_i && kh_take && st_ff.ptr != EXT_LAST_IDX)
      |=> st_ff.ptr == $past(st_ff.ptr) + 4'h1;
   endproperty
   a_kh_step: assert property (p_kh_step) // [R2]
      else $error("keyhole pointer did not advance");

   property p_kh_wrap;
      @(posedge clock_i) disable iff (!rst_n)
      (ce_i && kh_take && st_ff.ptr == EXT_LAST_IDX) |=> st_ff.ptr == EXT_FIRST_IDX;
   endproperty
   a_kh_wrap: assert property (p_kh_wrap) // [R15]
      else $error("keyhole pointer did not wrap");

   property p_bw_read;
      @(posedge clock_i) disable iff (!rst_n)
      s_read_of(OFS_BW) |=> s_axi_rvalid_o && s_axi_rdata_o == {24'h000000, $past(bw)};
   endproperty
   a_bw_read: assert property (p_bw_read) // [R6]
      else $error("bandwidth read wrong");

   property p_lanes_read;
      @(posedge clock_i) disable iff (!rst_n)
      s_read_of(OFS_LANES)
      |=> s_axi_rdata_o[4:0] == $past(lanes) && s_axi_rdata_o[31:5] == 27'h0000000;
   endproperty
   a_lanes_read: assert property (p_lanes_read) // [R7]
      else $error("lane count read wrong");

   property p_enh_read;
      @(posedge clock_i) disable iff (!rst_n)
      s_read_of(OFS_ENH) |=> s_axi_rdata_o == {31'h00000000, $past(enh)};
   endproperty
   a_enh_read: assert property (p_enh_read) // [R8]
      else $error("enhanced framing read wrong");

   property p_tp_read;
      @(posedge clock_i) disable iff (!rst_n)
      s_read_of(OFS_TP) |=> s_axi_rdata_o[1:0] == $past(tp) && s_axi_rresp_o == RESP_OKAY;
   endproperty
   a_tp_read: assert property (p_tp_read) // [R9]
      else $error("training pattern read wrong");

   property p_lqp_read;
      @(posedge clock_i) disable iff (!rst_n)
      s_read_of(OFS_LQP) |=> s_axi_rdata_o == {30'h00000000, $past(lqp)};
   endproperty
   a_lqp_read: assert property (p_lqp_read) // [R10]
      else $error("quality pattern read wrong");

   property p_scr_read;
      @(posedge clock_i) disable iff (!rst_n)
      s_read_of(OFS_SCR) |=> s_axi_rdata_o == {31'h00000000, $past(scr_off)};
   endproperty
   a_scr_read: assert property (p_scr_read) // [R12]
      else $error("scrambler flag read wrong");

   property p_err_read;
      @(posedge clock_i) disable iff (!rst_n)
      s_read_of(OFS_ERRSEL) |=> s_axi_rdata_o == {30'h00000000, $past(err_sel)};
   endproperty
   a_err_read: assert property (p_err_read) // [R13]
      else $error("error select read wrong");

   property p_test_clk;
      @(posedge clock_i) disable iff (!rst_n)
      ce_i |=> test_clk_o == $past(rclk_en && rec_clk_i);
   endproperty
   a_test_clk: assert property (p_test_clk) // [R11]
      else $error("test port does not follow recovered clock");

   property p_wr_refused;
      @(posedge clock_i) disable iff (!rst_n)
      (ce_i && aw_take && w_take && is_mapped(s_axi_awaddr_i))
      |=> s_axi_bvalid_o && s_axi_bresp_o == RESP_SLVERR;
   endproperty
   a_wr_refused: assert property (p_wr_refused) // [R14]
      else $error("write to mirror not refused");

   c_kh_wrap: cover property (@(posedge clock_i) disable iff (!rst_n)
      kh_take && st_ff.ptr == EXT_LAST_IDX);
   c_bw_fast: cover property (@(posedge clock_i) disable iff (!rst_n)
      s_axi_rvalid_o && s_axi_rdata_o[7:0] == BW_5G4);
   c_wr_resp: cover property (@(posedge clock_i) disable iff (!rst_n)
      s_axi_bvalid_o && s_axi_bready_i);
   c_unmapped: cover property (@(posedge clock_i) disable iff (!rst_n)
      s_axi_rvalid_o && s_axi_rresp_o == RESP_DECERR);
endmodule : sink_link_config_mirror

// ### tb/link_source_model.sv
// Behavioural remote link source driving the config and packet ports
`timescale 1ns/1ps
module link_source_model (
   input  wire logic       clock_i,
   output logic            cfg_we_o,
   output logic      [2:0] cfg_sel_o,
   output logic      [7:0] cfg_data_o,
   output logic            ext_byte_we_o,
   output logic      [5:0] ext_byte_idx_o,
   output logic      [7:0] ext_byte_o
);
   // =========================
   // Idle state
   initial begin
      cfg_we_o       = 1'b0;
      cfg_sel_o      = 3'h0;
      cfg_data_o     = 8'h5A;
      ext_byte_we_o  = 1'b0;
      ext_byte_idx_o = 6'h00;
      ext_byte_o     = 8'hA5;
   end
   // =========================
   // One config field write, after gap idle cycles
   task automatic put_cfg(input logic [2:0] sel, input logic [7:0] val, input int gap);
      @(posedge clock_i);
      repeat (gap) @(posedge clock_i);
      cfg_sel_o  <= sel;
      cfg_data_o <= val;
      cfg_we_o   <= 1'b1;
      @(posedge clock_i);
      cfg_we_o   <= 1'b0;
      cfg_data_o <= ~val;
   endtask : put_cfg
   // =========================
   // Whole packet: four header bytes and 32 payload bytes
   task automatic send_packet(input logic [7:0] b [36]);
      for (int i = 0; i < 36; i++) begin
         @(posedge clock_i);
         ext_byte_idx_o <= 6'(i);
         ext_byte_o     <= b[i];
         ext_byte_we_o  <= 1'b1;
      end
      @(posedge clock_i);
      ext_byte_we_o <= 1'b0;
      ext_byte_o    <= ~b[35];
   endtask : send_packet
   // =========================
   // One byte beyond the fixed packet length
   task automatic put_stray(input logic [5:0] idx, input logic [7:0] val);
      @(posedge clock_i);
      ext_byte_idx_o <= idx;
      ext_byte_o     <= val;
      ext_byte_we_o  <= 1'b1;
      @(posedge clock_i);
      ext_byte_we_o  <= 1'b0;
   endtask : put_stray
endmodule : link_source_model

// ### tb/sink_link_config_mirror_bench.sv
// Self-checking bench for the link configuration mirror
`timescale 1ns/1ps
module sink_link_config_mirror_bench import link_mirror_pkg::*;;
   localparam logic [7:0] MASK [8] = '{8'hFF, 8'h1F, 8'h01, 8'h03, 8'h03, 8'h01, 8'h01, 8'h03};
   localparam logic [7:0] BW_CODE [3] = '{BW_1G62, BW_2G7, BW_5G4};
   logic        clock_i, arst_n_i, ce_i, rec_clk_i, test_clk_o;
   logic [11:0] s_axi_awaddr_i, s_axi_araddr_i;
   logic        s_axi_awvalid_i, s_axi_awready_o, s_axi_wvalid_i, s_axi_wready_o;
   logic [31:0] s_axi_wdata_i, s_axi_rdata_o;
   logic [3:0]  s_axi_wstrb_i;
   logic [1:0]  s_axi_bresp_o, s_axi_rresp_o;
   logic        s_axi_bvalid_o, s_axi_bready_i, s_axi_arvalid_i, s_axi_arready_o;
   logic        s_axi_rvalid_o, s_axi_rready_i, cfg_we, ext_we, clk_chk, clk_exp, rflag_m;
   logic [2:0]  cfg_sel;
   logic [7:0]  cfg_data, ext_byte, v;
   logic [5:0]  ext_idx;
   logic [7:0]  cfg_m [8];
   logic [7:0]  pkt_m [36];
   int          n_errors, checked, cycles, ptr_m;
   integer      seed = 10274;
   // =========================
   // Design and source model
   sink_link_config_mirror i_dut (.clock_i(clock_i), .arst_n_i(arst_n_i), .ce_i(ce_i),
      .s_axi_awaddr_i(s_axi_awaddr_i), .s_axi_awvalid_i(s_axi_awvalid_i),
      .s_axi_awready_o(s_axi_awready_o), .s_axi_wdata_i(s_axi_wdata_i),
      .s_axi_wstrb_i(s_axi_wstrb_i), .s_axi_wvalid_i(s_axi_wvalid_i),
      .s_axi_wready_o(s_axi_wready_o), .s_axi_bresp_o(s_axi_bresp_o),
      .s_axi_bvalid_o(s_axi_bvalid_o), .s_axi_bready_i(s_axi_bready_i),
      .s_axi_araddr_i(s_axi_araddr_i), .s_axi_arvalid_i(s_axi_arvalid_i),
      .s_axi_arready_o(s_axi_arready_o), .s_axi_rdata_o(s_axi_rdata_o),
      .s_axi_rresp_o(s_axi_rresp_o), .s_axi_rvalid_o(s_axi_rvalid_o),
      .s_axi_rready_i(s_axi_rready_i), .cfg_we_i(cfg_we), .cfg_sel_i(cfg_sel),
      .cfg_data_i(cfg_data), .ext_byte_we_i(ext_we), .ext_byte_idx_i(ext_idx),
      .ext_byte_i(ext_byte), .rec_clk_i(rec_clk_i), .test_clk_o(test_clk_o));
   link_source_model i_src (.clock_i(clock_i), .cfg_we_o(cfg_we), .cfg_sel_o(cfg_sel),
      .cfg_data_o(cfg_data), .ext_byte_we_o(ext_we), .ext_byte_idx_o(ext_idx),
      .ext_byte_o(ext_byte));
   // =========================
   // Clock, timeout, recovered clock stimulus and check
   initial begin
      clock_i = 1'b0;
      forever #50 clock_i = ~clock_i;
   end
   always @(posedge clock_i) begin
      cycles++;
      if (cycles == 20000) begin
         n_errors++;
         report_and_stop();
      end
   end
   always @(posedge clock_i) begin
      rec_clk_i <= 1'($random(seed));
      clk_exp   <= rflag_m & rec_clk_i;
   end
   always @(negedge clock_i) begin
      if (clk_chk) check(32'(test_clk_o), 32'(clk_exp));
   end
   // =========================
   // Compare, bus tasks, verdict
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         n_errors++;
         $display("Error t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : check
   task automatic rd_chk(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
      logic [31:0] d;
      logic [1:0]  r;
      @(posedge clock_i);
      s_axi_araddr_i  <= a;
      s_axi_arvalid_i <= 1'b1;
      s_axi_rready_i  <= 1'b1;
      @(negedge clock_i);
      while (s_axi_arready_o !== 1'b1) @(negedge clock_i);
      @(posedge clock_i);
      s_axi_arvalid_i <= 1'b0;
      @(negedge clock_i);
      while (s_axi_rvalid_o !== 1'b1) @(negedge clock_i);
      d = s_axi_rdata_o;
      r = s_axi_rresp_o;
      @(posedge clock_i);
      s_axi_rready_i <= 1'b0;
      check(d, ed);
      check(32'(r), 32'(er));
   endtask : rd_chk
   task automatic wr_chk(input logic [11:0] a, input logic [1:0] er);
      logic ta, tw;
      logic da = 1'b0;
      logic dw = 1'b0;
      @(posedge clock_i);
      s_axi_awaddr_i  <= a;
      s_axi_awvalid_i <= 1'b1;
      s_axi_wdata_i   <= $random(seed);
      s_axi_wvalid_i  <= 1'b1;
      s_axi_bready_i  <= 1'b1;
      while (!(da && dw)) begin
         @(negedge clock_i);
         ta = !da && s_axi_awready_o === 1'b1;
         tw = !dw && s_axi_wready_o === 1'b1;
         @(posedge clock_i);
         if (ta) s_axi_awvalid_i <= 1'b0;
         if (tw) s_axi_wvalid_i <= 1'b0;
         da = da | ta;
         dw = dw | tw;
      end
      @(negedge clock_i);
      while (s_axi_bvalid_o !== 1'b1) @(negedge clock_i);
      check(32'(s_axi_bresp_o), 32'(er));
      @(posedge clock_i);
      s_axi_bready_i <= 1'b0;
   endtask : wr_chk
   task automatic rd_key(input logic [11:0] a);
      rd_chk(a, {pkt_m[4*ptr_m+3], pkt_m[4*ptr_m+2], pkt_m[4*ptr_m+1], pkt_m[4*ptr_m]},
             RESP_OKAY);
      ptr_m = (ptr_m + 1) % 9;
   endtask : rd_key
   task automatic rd_cfg(input int s);
      rd_chk(OFS_BW + 12'(4*s), 32'(cfg_m[s]), RESP_OKAY);
   endtask : rd_cfg
   task automatic report_and_stop();
      $display("Mismatches %0d, comparisons %0d", n_errors, checked);
      if (n_errors == 0 && checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : report_and_stop
   // =========================
   // Main sequence
   initial begin
      {arst_n_i, s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i} = 4'h0;
      {s_axi_arvalid_i, s_axi_rready_i, clk_chk, rflag_m, rec_clk_i} = 5'h00;
      ce_i           = 1'b1;
      s_axi_awaddr_i = 12'h000;
      s_axi_araddr_i = 12'h000;
      s_axi_wdata_i  = 32'h0000_0000;
      s_axi_wstrb_i  = 4'hF;
      foreach (cfg_m[i]) cfg_m[i] = 8'h00;
      repeat (5) @(posedge clock_i);
      arst_n_i <= 1'b1;
      for (int s = 0; s < 8; s++) rd_chk(OFS_BW + 12'(4*s), 32'h0, RESP_OKAY);
      for (int r = 0; r < 4; r++) begin
         for (int s = 0; s < 8; s++) begin
            v = (s == 0) ? BW_CODE[r % 3] : (s == 1) ? 8'(r + 1) : 8'(r);
            cfg_m[s] = v & MASK[s];
            i_src.put_cfg(3'(s), cfg_m[s] | (8'($random(seed)) & ~MASK[s]), r);
         end
         for (int s = 0; s < 8; s++)
            rd_cfg(s);
      end
      wr_chk(OFS_LANES, RESP_SLVERR);
      wr_chk(12'h500, RESP_DECERR);
      ce_i <= 1'b0;
      i_src.put_cfg(SEL_BW, ~cfg_m[0], 0);
      ce_i <= 1'b1;
      rd_cfg(0);
      rd_chk(OFS_LANES, 32'(cfg_m[1]), RESP_OKAY);
      rd_chk(12'h600, 32'h0, RESP_DECERR);
      for (int k = 0; k < 2; k++) begin
         foreach (pkt_m[i]) pkt_m[i] = 8'($random(seed));
         i_src.send_packet(pkt_m);
         i_src.put_stray(6'h24 + 6'(k), 8'h3C);
         for (int n = 0; n < 10; n++)
            rd_key(OFS_EXT_FIRST + 12'(4*k*(n % 9)));
      end
      for (int f = 1; f >= 0; f--) begin
         i_src.put_cfg(SEL_RCLK, 8'(f), 0);
         rflag_m = f[0];
         repeat (3) @(posedge clock_i);
         clk_chk = 1'b1;
         repeat (30) @(posedge clock_i);
         clk_chk = 1'b0;
      end
      report_and_stop();
   end
endmodule : sink_link_config_mirror_bench
